/* rtl/srap_dev.sv */
// Device end of the serial register access port with its register file.
// Assumes a host that drives select_n, sclk and sdi; all sampled by clk.
// Function
// RULE1 - Host keeps select low for whole access
// RULE2 - Sample serial input on rising edges
// RULE3 - No minimum serial clock rate
// RULE4 - Frame is 24 bits: direction, address, data
// RULE5 - Most significant bit first both ways
// RULE6 - First bit one reads, zero writes
// RULE7 - Next fifteen bits carry register address
// RULE8 - Write stores last eight bits received
// RULE9 - Read ignores input, shifts register out
// RULE10 - Output driven only during read data
// RULE11 - Streaming continues bytes while select low
// RULE12 - Address steps per byte, up by default
// RULE13 - Setup bits five and two set direction
// RULE14 - Hold bit stops address stepping
// RULE15 - Host avoids access during calibration
// RULE16 - Output changes on falling serial edge
// RULE17 - Short frames change no register
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
module srap_dev
   import srap_pkg::*;
#(
   parameter logic [7:0]  PART_CATEGORY = 8'h11,   // Arbitrary value
   parameter logic [15:0] PART_IDENT    = 16'h1234, // Arbitrary value
   parameter logic [7:0]  PART_REV      = 8'h01,   // Arbitrary value
   parameter logic [15:0] MAKER_IDENT   = 16'h5A5A  // Arbitrary value
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Serial link
   srap_link_if.dev_mp      link,
   // User side
   input  wire logic [23:0] sysref_capture_position,
   output logic      [7:0]  if_setup_a,
   output logic      [7:0]  dev_setup,
   output logic      [7:0]  user_serial_setup,
   output logic      [7:0]  clock_control_0,
   output logic      [7:0]  clock_control_1,
   output logic      [15:0] fs_adj_a,
   output logic      [15:0] fs_adj_b,
   output logic      [7:0]  ref_bypass
);

   typedef enum logic {PH_HDR, PH_DATA} srap_phase_type;

   logic [1:0]     sclk_q;
   logic           sclk_d_r;
   logic [1:0]     sel_q;
   logic [1:0]     sdi_q;
   srap_phase_type ph_r;
   logic [3:0]     hdr_cnt_r;
   logic [2:0]     bit_cnt_r;
   logic           rd_r;
   logic [14:0]    addr_r;
   logic [6:0]     rx_sh_r;
   logic [6:0]     tx_sh_r;
   logic           sdo_r;
   logic           oe_n_r;
   logic [7:0]     if_setup_a_r;
   logic [7:0]     dev_setup_r;
   logic [7:0]     user_serial_r;
   logic [7:0]     clock_control_0_r;
   logic [7:0]     clock_control_1_r;
   logic [15:0]    fs_adj_a_r;
   logic [15:0]    fs_adj_b_r;
   logic [7:0]     ref_bypass_r;
   logic [7:0]     tx_byte;

   // Readback of one register byte; multi-byte registers low byte first
   function automatic logic [7:0] rd_byte(input logic [14:0] a);
      case (a)
         OFS_IF_SETUP_A:        rd_byte = if_setup_a_r;
         OFS_DEV_SETUP:         rd_byte = dev_setup_r;
         OFS_PART_CAT:          rd_byte = PART_CATEGORY;
         OFS_PART_ID:           rd_byte = PART_IDENT[7:0];
         OFS_PART_ID + 15'h1:   rd_byte = PART_IDENT[15:8];
         OFS_PART_REV:          rd_byte = PART_REV;
         OFS_MAKER_ID:          rd_byte = MAKER_IDENT[7:0];
         OFS_MAKER_ID + 15'h1:  rd_byte = MAKER_IDENT[15:8];
         OFS_USER_SERIAL:       rd_byte = user_serial_r;
         OFS_CLOCK_CONTROL_0:         rd_byte = clock_control_0_r;
         OFS_CLOCK_CONTROL_1:         rd_byte = clock_control_1_r;
         OFS_SYSREF_CAPTURE_POSITION:        rd_byte = sysref_capture_position[7:0];
         OFS_SYSREF_CAPTURE_POSITION + 15'h1: rd_byte = sysref_capture_position[15:8];
         OFS_SYSREF_CAPTURE_POSITION + 15'h2: rd_byte = sysref_capture_position[23:16];
         OFS_FS_ADJ_A:          rd_byte = fs_adj_a_r[7:0];
         OFS_FS_ADJ_A + 15'h1:  rd_byte = fs_adj_a_r[15:8];
         OFS_FS_ADJ_B:          rd_byte = fs_adj_b_r[7:0];
         OFS_FS_ADJ_B + 15'h1:  rd_byte = fs_adj_b_r[15:8];
         OFS_REF_BYPASS:        rd_byte = ref_bypass_r;
         default:               rd_byte = 8'h00;
      endcase
   endfunction

   // Edge and level decode of synchronised pins
   wire        sclk_rise = sclk_q[1] & ~sclk_d_r;   // [RULE2] [RULE3]
   wire        sclk_fall = ~sclk_q[1] & sclk_d_r;   // [RULE16]
   wire        sel_act   = ~sel_q[1];               // [RULE1]
   wire        rise_go   = sel_act & sclk_rise;
   wire        byte_end  = rise_go & (ph_r == PH_DATA) & (bit_cnt_r == 3'h7);
   wire        wr_go     = byte_end & ~rd_r;        // [RULE8] [RULE17]
   wire [7:0]  wr_data   = {rx_sh_r, sdi_q[1]};     // [RULE5]
   wire        addr_up   = if_setup_a_r[ASC_BIT_HI] | if_setup_a_r[ASC_BIT_LO]; // [RULE13]
   wire        addr_hold = user_serial_r[HOLD_BIT]; // [RULE14]
   wire [14:0] addr_next = addr_hold ? addr_r :
                           (addr_up ? addr_r + 15'h1 : addr_r - 15'h1); // [RULE12]

   // Read byte; re-evaluated when any register changes, not only the address
   always_comb
   begin
      tx_byte = rd_byte(addr_r);                    // [RULE9]
   end

   // Two-stage synchronisers plus delayed clock for edge finding
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_q   <= 2'h0;
         sclk_d_r <= 1'b0;
         sel_q    <= 2'h3;
         sdi_q    <= 2'h0;
      end
      else
      begin
         sclk_q   <= {sclk_q[0], link.sclk};
         sclk_d_r <= sclk_q[1];
         sel_q    <= {sel_q[0], link.select_n};
         sdi_q    <= {sdi_q[0], link.sdi};
      end
   end

   // Receive side: header then data bytes
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ph_r      <= PH_HDR;
         hdr_cnt_r <= 4'h0;
         bit_cnt_r <= 3'h0;
         rd_r      <= 1'b0;
         addr_r    <= 15'h0;
         rx_sh_r   <= 7'h0;
      end
      else if (!sel_act)
      begin
         ph_r      <= PH_HDR;                       // [RULE17]
         hdr_cnt_r <= 4'h0;
         bit_cnt_r <= 3'h0;
      end
      else if (rise_go)
      begin
         case (ph_r)
            PH_HDR:
            begin
               if (hdr_cnt_r == 4'h0)
                  rd_r <= sdi_q[1];                 // [RULE6]
               else
                  addr_r <= {addr_r[13:0], sdi_q[1]}; // [RULE7] [RULE5]
               hdr_cnt_r <= hdr_cnt_r + 4'h1;
               if (hdr_cnt_r == 4'(HDR_BITS - 1))
                  ph_r <= PH_DATA;                  // [RULE4]
            end
            PH_DATA:
            begin
               rx_sh_r   <= {rx_sh_r[5:0], sdi_q[1]};
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (bit_cnt_r == 3'h7)
                  addr_r <= addr_next;              // [RULE11] [RULE12]
            end
            default: ph_r <= PH_HDR;
         endcase
      end
   end

   // Transmit side: drive read data from falling edges only
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sdo_r   <= 1'b0;
         oe_n_r  <= 1'b1;
         tx_sh_r <= 7'h0;
      end
      else if (!sel_act || !rd_r || ph_r != PH_DATA)
         oe_n_r <= 1'b1;                            // [RULE10]
      else if (sclk_fall)
      begin
         oe_n_r <= 1'b0;                            // [RULE10]
         if (bit_cnt_r == 3'h0)
            {sdo_r, tx_sh_r} <= tx_byte;            // [RULE9] [RULE11] [RULE16]
         else
            {sdo_r, tx_sh_r} <= {tx_sh_r, 1'b0};    // [RULE5]
      end
   end

   // Writable register file
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         if_setup_a_r  <= RST_IF_SETUP_A;
         dev_setup_r   <= RST_DEV_SETUP;
         user_serial_r <= RST_USER_SERIAL;
         clock_control_0_r   <= RST_CLOCK_CONTROL_0;
         clock_control_1_r   <= RST_CLOCK_CONTROL_1;
         fs_adj_a_r    <= RST_FS_ADJ;
         fs_adj_b_r    <= RST_FS_ADJ;
         ref_bypass_r  <= RST_REF_BYPASS;
      end
      else if (wr_go)
      begin
         case (addr_r)                              // [RULE8]
            OFS_IF_SETUP_A:       if_setup_a_r      <= wr_data;
            OFS_DEV_SETUP:        dev_setup_r       <= wr_data;
            OFS_USER_SERIAL:      user_serial_r     <= wr_data;
            OFS_CLOCK_CONTROL_0:        clock_control_0_r       <= wr_data;
            OFS_CLOCK_CONTROL_1:        clock_control_1_r       <= wr_data;
            OFS_FS_ADJ_A:         fs_adj_a_r[7:0]   <= wr_data;
            OFS_FS_ADJ_A + 15'h1: fs_adj_a_r[15:8]  <= wr_data;
            OFS_FS_ADJ_B:         fs_adj_b_r[7:0]   <= wr_data;
            OFS_FS_ADJ_B + 15'h1: fs_adj_b_r[15:8]  <= wr_data;
            OFS_REF_BYPASS:       ref_bypass_r      <= wr_data;
            default:              ref_bypass_r      <= ref_bypass_r;
         endcase
      end
   end

   // Outputs straight from flops
   assign link.sdo_out      = sdo_r;
   assign link.sdo_oe_n     = oe_n_r;
   assign if_setup_a        = if_setup_a_r;
   assign dev_setup         = dev_setup_r;
   assign user_serial_setup = user_serial_r;
   assign clock_control_0         = clock_control_0_r;
   assign clock_control_1         = clock_control_1_r;
   assign fs_adj_a          = fs_adj_a_r;
   assign fs_adj_b          = fs_adj_b_r;
   assign ref_bypass        = ref_bypass_r;

endmodule

/* rtl/srap_pkg.sv */
// Shared constants for the serial register access port, both ends.
// Assumes one system clock of 250 MHz on each end.
package srap_pkg;
   // Frame layout
   localparam int FRAME_BITS = 24;
   localparam int HDR_BITS   = 16;
   localparam int ADDR_W     = 15;
   localparam int DATA_W     = 8;
   // Device register offsets
   localparam logic [14:0] OFS_IF_SETUP_A  = 15'h000;
   localparam logic [14:0] OFS_DEV_SETUP   = 15'h002;
   localparam logic [14:0] OFS_PART_CAT    = 15'h003;
   localparam logic [14:0] OFS_PART_ID     = 15'h004;
   localparam logic [14:0] OFS_PART_REV    = 15'h006;
   localparam logic [14:0] OFS_MAKER_ID    = 15'h00C;
   localparam logic [14:0] OFS_USER_SERIAL = 15'h010;
   localparam logic [14:0] OFS_CLOCK_CONTROL_0   = 15'h029;
   localparam logic [14:0] OFS_CLOCK_CONTROL_1   = 15'h02A;
   localparam logic [14:0] OFS_SYSREF_CAPTURE_POSITION  = 15'h02C;
   localparam logic [14:0] OFS_FS_ADJ_A    = 15'h030;
   localparam logic [14:0] OFS_FS_ADJ_B    = 15'h032;
   localparam logic [14:0] OFS_REF_BYPASS  = 15'h038;
   // Reset values
   localparam logic [7:0]  RST_IF_SETUP_A  = 8'h30;
   localparam logic [7:0]  RST_DEV_SETUP   = 8'h00;
   localparam logic [7:0]  RST_USER_SERIAL = 8'h00;
   localparam logic [7:0]  RST_CLOCK_CONTROL_0   = 8'h00;
   localparam logic [7:0]  RST_CLOCK_CONTROL_1   = 8'h20;
   localparam logic [15:0] RST_FS_ADJ      = 16'hA000;
   localparam logic [7:0]  RST_REF_BYPASS  = 8'h00;
   // Field positions
   localparam int ASC_BIT_HI = 5;
   localparam int ASC_BIT_LO = 2;
   localparam int HOLD_BIT   = 0;
   // Host command registers
   localparam logic [1:0] HOFS_ADDR   = 2'h0;
   localparam logic [1:0] HOFS_DATA   = 2'h1;
   localparam logic [1:0] HOFS_CTRL   = 2'h2;
   localparam logic [1:0] HOFS_STATUS = 2'h3;
   localparam int CTRL_START = 0;
   localparam int CTRL_READ  = 1;
   localparam int CTRL_KEEP  = 2;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_OPEN  = 1;
   // Host serial clock timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int SCLK_HALF_NS  = 64;
   localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* rtl/srap_link_if.sv */
// Four-wire serial link between host controller and device.
// Assumes the bench or top joins one device instance to one host instance or to bench drive.
`timescale 1ns/10ps
interface srap_link_if;
   logic select_n;
   logic sclk;
   logic sdi;
   logic sdo_out;
   logic sdo_oe_n;
   wire  sdo_line;

   // Released output reads as its pull-up level
   assign sdo_line = sdo_oe_n ? 1'b1 : sdo_out;

   modport dev_mp (input select_n, input sclk, input sdi, output sdo_out, output sdo_oe_n);
   modport host_mp (output select_n, output sclk, output sdi, input sdo_line);
endinterface

/* rtl/srap_host.sv */
// Host controller end: turns register commands into serial frames.
// Assumes software on a simple strobe port; serial clock made by divider.
`timescale 1ns/10ps
module srap_host
   import srap_pkg::*;
#(
   parameter int HALF_CYC = SCLK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Command port
   input  wire logic [1:0]  cmd_addr,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   output logic      [15:0] cmd_rdata,
   // Serial link
   srap_link_if.host_mp     link
);

   typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_GAP} srap_hstate_type;

   srap_hstate_type st_r;
   logic [14:0]     addr_r;
   logic [7:0]      wdata_r;
   logic [7:0]      rx_r;
   logic            keep_r;
   logic            open_r;
   logic [23:0]     tx_r;
   logic [4:0]      bits_r;
   logic [15:0]     div_r;
   logic            sel_n_r;
   logic            sclk_r;
   logic            sdi_r;
   logic [1:0]      sdo_q;
   logic [15:0]     rdata_r;

   // Command decode
   wire        start    = cmd_wr & (cmd_addr == HOFS_CTRL) & cmd_wdata[CTRL_START]
                          & (st_r == HS_IDLE);       // [RULE15]
   wire        cont     = start & open_r;            // [RULE11]
   wire [23:0] frame    = {cmd_wdata[CTRL_READ], addr_r, wdata_r}; // [RULE4] [RULE6] [RULE7]
   wire        half_end = (div_r == 16'(HALF_CYC - 1));
   wire [15:0] status   = {14'h0, open_r, st_r != HS_IDLE};

   // Command registers and readback one cycle later
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         addr_r  <= 15'h0;
         wdata_r <= 8'h00;
         keep_r  <= 1'b0;
         rdata_r <= 16'h0;
         sdo_q   <= 2'h0;
      end
      else
      begin
         sdo_q <= {sdo_q[0], link.sdo_line};
         if (cmd_wr && cmd_addr == HOFS_ADDR)
            addr_r <= cmd_wdata[14:0];
         if (cmd_wr && cmd_addr == HOFS_DATA)
            wdata_r <= cmd_wdata[7:0];
         if (start)
            keep_r <= cmd_wdata[CTRL_KEEP];
         if (cmd_rd)
            case (cmd_addr)
               HOFS_ADDR:   rdata_r <= {1'b0, addr_r};
               HOFS_DATA:   rdata_r <= {8'h00, rx_r};
               HOFS_STATUS: rdata_r <= status;
               default:     rdata_r <= 16'h0;
            endcase
      end
   end

   // Frame sequencer and serial clock divider
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r    <= HS_IDLE;
         tx_r    <= 24'h0;
         bits_r  <= 5'h0;
         div_r   <= 16'h0;
         sel_n_r <= 1'b1;
         sclk_r  <= 1'b0;
         sdi_r   <= 1'b0;
         rx_r    <= 8'h00;
         open_r  <= 1'b0;
      end
      else
      begin
         div_r <= half_end ? 16'h0 : div_r + 16'h1;
         case (st_r)
            HS_IDLE:
            begin
               div_r <= 16'h0;
               if (start)
               begin
                  sel_n_r <= 1'b0;                   // [RULE1]
                  st_r    <= HS_LOW;
                  if (cont)
                  begin
                     tx_r   <= {wdata_r, 16'h0};
                     sdi_r  <= wdata_r[7];
                     bits_r <= 5'(DATA_W);
                  end
                  else
                  begin
                     tx_r   <= frame;
                     sdi_r  <= frame[23];             // [RULE5]
                     bits_r <= 5'(FRAME_BITS);
                  end
               end
            end
            HS_LOW:
               if (half_end)
               begin
                  if (bits_r == 5'h0)
                  begin
                     open_r <= keep_r;
                     if (keep_r)
                        st_r <= HS_IDLE;
                     else
                     begin
                        sel_n_r <= 1'b1;
                        st_r    <= HS_GAP;
                     end
                  end
                  else
                  begin
                     sclk_r <= 1'b1;
                     st_r   <= HS_HIGH;
                  end
               end
            HS_HIGH:
               if (half_end)
               begin
                  rx_r   <= {rx_r[6:0], sdo_q[1]};     // [RULE16]
                  sclk_r <= 1'b0;
                  tx_r   <= {tx_r[22:0], 1'b0};
                  sdi_r  <= tx_r[22];
                  bits_r <= bits_r - 5'h1;
                  st_r   <= HS_LOW;
               end
            HS_GAP:
               if (half_end)
                  st_r <= HS_IDLE;
            default: st_r <= HS_IDLE;
         endcase
      end
   end

   // Outputs straight from flops
   assign cmd_rdata     = rdata_r;
   assign link.select_n = sel_n_r;
   assign link.sclk     = sclk_r;
   assign link.sdi      = sdi_r;

endmodule

/* tb/srap_checker.sv */
// Concurrent checks on the serial link joining host and device ends.
// Assumes plain inputs taken from the link interface inside tb.
`timescale 1ns/10ps
module srap_checker
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Link signals
   input wire logic select_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo_out,
   input wire logic sdo_oe_n
);
   logic       sclk_r;
   logic [7:0] cnt_r;
   logic       dir_r;
   wire        rise_w;

   // Rising serial edge as seen by the system clock
   assign rise_w = sclk & ~sclk_r;

   // Count rising edges per frame, keep the direction bit
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclk_r <= 1'b0;
         cnt_r  <= 8'h00;
         dir_r  <= 1'b0;
      end
      else
      begin
         sclk_r <= sclk;
         cnt_r  <= select_n ? 8'h00 : (rise_w ? cnt_r + 8'h01 : cnt_r);
         dir_r  <= (rise_w && !select_n && cnt_r == 8'h00) ? sdi : dir_r;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_sclk_idle; select_n |-> !sclk; endproperty
   a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high outside a frame");
   property p_sclk_high; $rose(sclk) |=> sclk [*3]; endproperty
   a_sclk_high: assert property (p_sclk_high) else $error("sclk high half too short");
   property p_frame_len; $rose(select_n) |-> cnt_r >= 8'd24 && cnt_r[2:0] == 3'h0; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
   property p_sdi_move; $changed(sdi) && !select_n && !$past(select_n) |-> !sclk; endproperty
   a_sdi_move: assert property (p_sdi_move) else $error("sdi moved while sclk high");
   property p_oe_hdr; !select_n && cnt_r < 8'd16 |-> sdo_oe_n; endproperty
   a_oe_hdr: assert property (p_oe_hdr) else $error("sdo driven in header");
   property p_oe_wr; !select_n && cnt_r != 8'h00 && !dir_r |-> sdo_oe_n; endproperty
   a_oe_wr: assert property (p_oe_wr) else $error("sdo driven in write frame");
   property p_oe_rd; !select_n && cnt_r >= 8'd17 && dir_r |-> !sdo_oe_n; endproperty
   a_oe_rd: assert property (p_oe_rd) else $error("sdo not driven in read data");
   property p_oe_off; select_n [*6] |-> sdo_oe_n; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo still driven after frame");
   property p_sdo_move; $changed(sdo_out) && !sdo_oe_n && !$past(sdo_oe_n) |-> !sclk; endproperty
   a_sdo_move: assert property (p_sdo_move) else $error("sdo moved while sclk high");
endmodule

/* tb/tb.sv */
// Bench joining host and device ends; a second device on a bench-driven link.
// Assumes the rtl package, link interface and both design ends.
`timescale 1ns/10ps
module tb
   import srap_pkg::*;
;
   typedef struct packed {logic [14:0] a; logic [7:0] d; logic [7:0] e;} srap_row_type;
   localparam int NROW = 20;
   localparam int LB_HALF = 16; // Half period of the bench serial clock, 64 ns
   localparam logic [23:0] SYSREF = 24'hC0FFEE;
   localparam srap_row_type ROWS [NROW] = '{
      '{15'h000, 8'h24, 8'h24}, '{15'h002, 8'h5A, 8'h5A}, '{15'h010, 8'h80, 8'h80},
      '{15'h029, 8'hC3, 8'hC3}, '{15'h02A, 8'h3C, 8'h3C}, '{15'h030, 8'h11, 8'h11},
      '{15'h031, 8'h22, 8'h22}, '{15'h032, 8'h33, 8'h33}, '{15'h033, 8'h44, 8'h44},
      '{15'h038, 8'h7E, 8'h7E}, '{15'h003, 8'hFF, 8'h11}, '{15'h004, 8'hFF, 8'h34},
      '{15'h005, 8'hFF, 8'h12}, '{15'h006, 8'hFF, 8'h01}, '{15'h00C, 8'hFF, 8'h5A},
      '{15'h00D, 8'hFF, 8'h5A}, '{15'h02C, 8'hFF, 8'hEE}, '{15'h02D, 8'hFF, 8'hFF},
      '{15'h02E, 8'hFF, 8'hC0}, '{15'h001, 8'hAA, 8'h00}};
   logic        clk, sys_rst, cmd_wr, cmd_rd, sclk_q;
   logic [1:0]  cmd_addr;
   logic [15:0] cmd_wdata, cmd_rdata, v, v2, fs_adj_a, fs_adj_b;
   logic [7:0]  if_setup_a, dev_setup, user_serial_setup, clock_control_0, clock_control_1;
   logic [7:0]  ref_bypass, rb_b, g;
   logic [23:0] mon_sh;
   int          err_total, checks;

   srap_link_if u_link ();
   srap_link_if u_link_b ();
   srap_dev u_srap_dev (.clk(clk), .sys_rst(sys_rst), .link(u_link), .sysref_capture_position(SYSREF),
      .if_setup_a(if_setup_a), .dev_setup(dev_setup), .user_serial_setup(user_serial_setup),
      .clock_control_0(clock_control_0), .clock_control_1(clock_control_1), .fs_adj_a(fs_adj_a), .fs_adj_b(fs_adj_b),
      .ref_bypass(ref_bypass));
   srap_host #(.HALF_CYC(8)) u_srap_host (.clk(clk), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
      .link(u_link));
   srap_dev u_srap_dev_b (.clk(clk), .sys_rst(sys_rst), .link(u_link_b), .sysref_capture_position(SYSREF),
      .if_setup_a(), .dev_setup(), .user_serial_setup(), .clock_control_0(), .clock_control_1(),
      .fs_adj_a(), .fs_adj_b(), .ref_bypass(rb_b));
   srap_checker u_srap_checker (.clk(clk), .sys_rst(sys_rst), .select_n(u_link.select_n),
      .sclk(u_link.sclk), .sdi(u_link.sdi), .sdo_out(u_link.sdo_out),
      .sdo_oe_n(u_link.sdo_oe_n));

   // System clock, 4 ns period
   always #2 clk = ~clk;

   // Capture sdi at each rising serial edge of the host link
   always @(posedge clk)
   begin
      sclk_q <= u_link.sclk;
      if (u_link.sclk && !sclk_q && !u_link.select_n)
         mon_sh <= {mon_sh[22:0], u_link.sdi};
   end

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Command port write and read, one strobe cycle each
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      cmd_addr  <= a;
      cmd_wdata <= d;
      cmd_wr    <= 1'b1;
      @(posedge clk);
      cmd_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      cmd_addr <= a;
      cmd_rd   <= 1'b1;
      @(posedge clk);
      cmd_rd <= 1'b0;
      @(posedge clk);
      d = cmd_rdata;
   endtask

   task automatic wait_idle;
      logic [15:0] s;
      for (int k = 0; k < 300; k++)
      begin
         rd(HOFS_STATUS, s);
         if (s[STAT_BUSY] === 1'b0)
            return;
      end
      err_total++;
      summarize();
   endtask

   task automatic frame(input logic r, input logic [14:0] a, input logic [7:0] d, input logic k);
      wr(HOFS_ADDR, {1'b0, a});
      wr(HOFS_DATA, {8'h00, d});
      wr(HOFS_CTRL, {13'h0000, k, r, 1'b1});
      wait_idle();
   endtask

   task automatic more(input logic [7:0] d, input logic k);
      wr(HOFS_DATA, {8'h00, d});
      wr(HOFS_CTRL, {13'h0000, k, 2'b01});
      wait_idle();
   endtask

   // Bench-driven frame of n bits on the second link, optional stop before the rising edge of bit 12
   task automatic lb_frame(input int n, input logic [23:0] f, input int stall,
                           output logic [7:0] got);
      logic zbad;
      zbad = 1'b0;
      got  = 8'h00;
      @(posedge clk);
      u_link_b.select_n <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         u_link_b.sdi <= f[23-i];
         repeat (LB_HALF) @(posedge clk);
         if (i == 12)
            repeat (stall) @(posedge clk);
         got = {got[6:0], u_link_b.sdo_line};
         if ((i < 16 || !f[23]) && u_link_b.sdo_oe_n !== 1'b1)
            zbad = 1'b1;
         u_link_b.sclk <= 1'b1;
         repeat (LB_HALF) @(posedge clk);
         u_link_b.sclk <= 1'b0;
      end
      repeat (LB_HALF) @(posedge clk);
      u_link_b.select_n <= 1'b1;
      u_link_b.sdi      <= ~u_link_b.sdi;
      repeat (LB_HALF) @(posedge clk);
      chk({23'h000000, zbad}, 24'h000000);
   endtask

   // Main sequence
   initial
   begin
      clk = 1'b0;
      sys_rst = 1'b1;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_addr = 2'h0;
      cmd_wdata = 16'h0000;
      u_link_b.select_n = 1'b1;
      u_link_b.sclk = 1'b0;
      u_link_b.sdi = 1'b0;
      err_total = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({if_setup_a, clock_control_1, ref_bypass}, {RST_IF_SETUP_A, RST_CLOCK_CONTROL_1, 8'h00});
      chk({dev_setup, fs_adj_b}, {RST_DEV_SETUP, RST_FS_ADJ});
      chk({21'h0, u_link.select_n, u_link.sdo_oe_n, u_link.sclk}, 24'h000006);
      for (int i = 0; i < NROW; i++)
      begin
         frame(1'b0, ROWS[i].a, ROWS[i].d, 1'b0);
         if (i == 0)
            chk(mon_sh, {1'b0, ROWS[0].a, ROWS[0].d});
         frame(1'b1, ROWS[i].a, 8'hFF, 1'b0);
         rd(HOFS_DATA, v);
         chk({16'h0000, v[7:0]}, {16'h0000, ROWS[i].e});
      end
      chk({if_setup_a, fs_adj_a}, 24'h242211);
      chk({dev_setup, fs_adj_b}, 24'h5A4433);
      // Streaming write, ascending
      frame(1'b0, OFS_CLOCK_CONTROL_0, 8'h81, 1'b1);
      more(8'h82, 1'b0);
      chk({8'h00, clock_control_0, clock_control_1}, 24'h008182);
      // Streaming write, descending
      frame(1'b0, OFS_IF_SETUP_A, 8'h00, 1'b0);
      frame(1'b0, 15'h031, 8'hA1, 1'b1);
      more(8'hA2, 1'b0);
      chk({8'h00, fs_adj_a}, 24'h00A1A2);
      // Streaming read, ascending through bit 2 alone
      frame(1'b0, OFS_IF_SETUP_A, 8'h04, 1'b0);
      frame(1'b1, OFS_PART_ID, 8'h00, 1'b1);
      rd(HOFS_STATUS, v2);
      chk({8'h00, v2}, 24'h000002);
      rd(HOFS_DATA, v);
      more(8'h00, 1'b0);
      rd(HOFS_DATA, v2);
      chk({8'h00, v[7:0], v2[7:0]}, 24'h003412);
      // Address hold keeps the stream on one register
      frame(1'b0, OFS_USER_SERIAL, 8'h01, 1'b0);
      frame(1'b0, OFS_REF_BYPASS, 8'h55, 1'b1);
      more(8'h66, 1'b0);
      chk({8'h00, user_serial_setup, ref_bypass}, 24'h000166);
      // Second link: cut frame, stopped clock, read with data ignored
      lb_frame(20, {1'b0, OFS_REF_BYPASS, 8'hFF}, 0, g);
      chk({16'h0000, rb_b}, 24'h000000);
      lb_frame(24, {1'b0, OFS_REF_BYPASS, 8'hC5}, 2000, g);
      chk({16'h0000, rb_b}, 24'h0000C5);
      lb_frame(24, {1'b1, OFS_REF_BYPASS, 8'h3A}, 0, g);
      chk({8'h00, g, rb_b}, 24'h00C5C5);
      summarize();
   end
endmodule
